// File: design/ioxi_top.sv
// What this block does
// - the alert is pulled low when any input-configured pin changes level.
// - the alert is released once every changed pin is back at its old level.
// - reading the input register releases the alert and rebases the reference.
// - turning an output into an input may raise a spurious alert.
// - a power-on pulse holds all logic in reset until supply is valid.
// - after power-on release every register takes its default value.
// - command 0x00 reads pin levels for all pins; writes are ignored.
// - command 0x03 is direction, set bit means input, defaults all set.
// - command 0x02 inverts input register bits, defaults all clear.
// - command 0x01 drives output pins, defaults ones, reads the flop.
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
module ioxi_top (
	input  wire logic                       sys_clk,
	input  wire logic                       rst,
	input  wire logic                       supply_ok,
	input  wire logic [ioxi_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	output logic      [31:0]                avs_readdata,
	output logic                            avs_waitrequest,
	input  wire logic [7:0]                 pin_in,
	output ioxi_pkg::ioxi_pins_type         pin_out,
	output logic                            alert_out,
	output logic                            alert_oe_n
);
	// ==========================================================
	// power-on reset
	logic [1:0] sup_sync_reg;
	logic [7:0] por_cnt_reg;
	logic       por_reg;
	logic       hold;
	assign hold = rst | por_reg;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sup_sync_reg <= 2'b00;
		end else begin
			sup_sync_reg <= {sup_sync_reg[0], supply_ok};
		end
	end

	// count a minimum hold after supply is seen valid
	always_ff @(posedge sys_clk) begin
		if (rst || !sup_sync_reg[1]) begin
			por_cnt_reg <= 8'h00;
			por_reg     <= 1'b1;
		end else if (por_cnt_reg < 8'(ioxi_pkg::POR_CYCLES)) begin
			por_cnt_reg <= por_cnt_reg + 8'h01;
			por_reg     <= 1'b1;
		end else begin
			por_reg     <= 1'b0;
		end
	end

	// ==========================================================
	// pin synchroniser
	logic [7:0] pin_s1_reg;
	logic [7:0] pin_s2_reg;
	always_ff @(posedge sys_clk) begin
		if (hold) begin
			pin_s1_reg <= ioxi_pkg::RST_INPUT;
			pin_s2_reg <= ioxi_pkg::RST_INPUT;
		end else begin
			pin_s1_reg <= pin_in;
			pin_s2_reg <= pin_s1_reg;
		end
	end

	// ==========================================================
	// registers
	logic [7:0] out_reg;
	logic [7:0] inv_reg;
	logic [7:0] dir_reg;
	logic       wr_acc;
	logic       rd_acc;
	logic [7:0] cmd;
	assign cmd    = 8'(avs_address[ioxi_pkg::ADDR_W-1:2]);
	assign wr_acc = avs_write & ~avs_waitrequest;
	assign rd_acc = avs_read & ~avs_waitrequest;

	always_ff @(posedge sys_clk) begin
		if (hold) begin
			out_reg <= ioxi_pkg::RST_OUTPUT;
			inv_reg <= ioxi_pkg::RST_INVERT;
			dir_reg <= ioxi_pkg::RST_DIR;
		end else if (wr_acc) begin
			case (cmd)
				ioxi_pkg::CMD_OUTPUT: out_reg <= avs_writedata[7:0];
				ioxi_pkg::CMD_INVERT: inv_reg <= avs_writedata[7:0];
				ioxi_pkg::CMD_DIR:    dir_reg <= avs_writedata[7:0];
				default: ; // input register writes dropped
			endcase
		end
	end

	// ==========================================================
	// change detection
	logic [7:0] ref_reg;
	logic [7:0] snap_reg;
	logic [7:0] changed;
	logic       rd_input;
	assign rd_input = rd_acc && cmd == ioxi_pkg::CMD_INPUT;

	// pins as returned to the host; a change after the snapshot still alerts
	always_ff @(posedge sys_clk) begin
		if (hold) begin
			snap_reg <= ioxi_pkg::RST_INPUT;
		end else if (avs_read && wait_reg && cmd == ioxi_pkg::CMD_INPUT) begin
			snap_reg <= pin_s2_reg;
		end
	end
	// a pin just turned to input is compared with a stale reference
	assign changed  = (pin_s2_reg ^ ref_reg) & dir_reg;

	always_ff @(posedge sys_clk) begin
		if (hold) begin
			ref_reg <= ioxi_pkg::RST_INPUT;
		end else if (rd_input) begin
			ref_reg <= snap_reg;
		end
	end

	// alert follows difference, so returning pins release it
	always_ff @(posedge sys_clk) begin
		if (hold) begin
			alert_oe_n <= 1'b1;
		end else if (rd_input) begin
			alert_oe_n <= 1'b1;
		end else begin
			alert_oe_n <= ~(|changed);
		end
	end
	assign alert_out = 1'b0;

	// ==========================================================
	// bus slave: one wait state per access
	logic wait_reg;
	always_ff @(posedge sys_clk) begin
		if (hold) begin
			wait_reg <= 1'b1;
		end else if ((avs_read || avs_write) && wait_reg) begin
			wait_reg <= 1'b0;
		end else begin
			wait_reg <= 1'b1;
		end
	end
	assign avs_waitrequest = wait_reg;

	always_ff @(posedge sys_clk) begin
		if (hold) begin
			avs_readdata <= ioxi_pkg::UNMAPPED_READ;
		end else if ((avs_read) && wait_reg) begin
			case (cmd)
				ioxi_pkg::CMD_INPUT:
					avs_readdata <= {24'h00_0000, pin_s2_reg ^ inv_reg};
				ioxi_pkg::CMD_OUTPUT:
					avs_readdata <= {24'h00_0000, out_reg};
				ioxi_pkg::CMD_INVERT:
					avs_readdata <= {24'h00_0000, inv_reg};
				ioxi_pkg::CMD_DIR:
					avs_readdata <= {24'h00_0000, dir_reg};
				ioxi_pkg::CMD_STATUS:
					avs_readdata <= {23'h00_0000, ~alert_oe_n, changed};
				default:
					avs_readdata <= ioxi_pkg::UNMAPPED_READ;
			endcase
		end
	end

	// ==========================================================
	// pin drivers: oe low means driven
	always_ff @(posedge sys_clk) begin
		if (hold) begin
			pin_out <= '{drive: ioxi_pkg::RST_OUTPUT, oe_n: ioxi_pkg::RST_DIR};
		end else begin
			pin_out <= '{drive: out_reg, oe_n: dir_reg};
		end
	end

	// ==========================================================
	// checks
	property p_alert_on_change;
		@(posedge sys_clk) disable iff (hold)
		(|changed && !rd_input) |=> !alert_oe_n;
	endproperty
	a_alert_on_change: assert property (p_alert_on_change)
		else $error("alert not raised on change");

	property p_release_on_return;
		@(posedge sys_clk) disable iff (hold)
		(changed == 8'h00) |=> alert_oe_n;
	endproperty
	a_release_on_return: assert property (p_release_on_return)
		else $error("alert held with no change");

	property p_read_clears;
		@(posedge sys_clk) disable iff (hold)
		rd_input |=> (alert_oe_n && ref_reg == $past(snap_reg));
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("input read did not clear alert");

	property p_por_hold;
		@(posedge sys_clk) disable iff (rst)
		!sup_sync_reg[1] |=> por_reg;
	endproperty
	a_por_hold: assert property (p_por_hold)
		else $error("logic left reset without supply");

	property p_defaults;
		@(posedge sys_clk)
		$fell(por_reg) |-> (dir_reg == 8'hff && out_reg == 8'hff
			&& inv_reg == 8'h00);
	endproperty
	a_defaults: assert property (p_defaults)
		else $error("registers not at defaults");

	property p_input_ro;
		@(posedge sys_clk) disable iff (hold)
		(wr_acc && cmd == ioxi_pkg::CMD_INPUT) |=> $stable(out_reg)
			&& $stable(inv_reg) && $stable(dir_reg);
	endproperty
	a_input_ro: assert property (p_input_ro)
		else $error("input register write changed state");

	property p_dir_write;
		@(posedge sys_clk) disable iff (hold)
		(wr_acc && cmd == ioxi_pkg::CMD_DIR) |=> ##1
			pin_out.oe_n == $past(avs_writedata[7:0], 2);
	endproperty
	a_dir_write: assert property (p_dir_write)
		else $error("direction not applied");

	property p_out_pins_quiet;
		@(posedge sys_clk) disable iff (hold)
		((changed == 8'h00) && |((pin_s2_reg ^ ref_reg) & ~dir_reg))
			|=> alert_oe_n;
	endproperty
	a_out_pins_quiet: assert property (p_out_pins_quiet)
		else $error("output pins raised alert");

	property p_one_wait;
		@(posedge sys_clk) disable iff (hold)
		($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest
			##1 !avs_waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("bus answer not after one wait");
endmodule

// File: common/ioxi_pkg.sv
package ioxi_pkg;
	// ==========================================================
	// register map (byte addresses = command value times four)
	localparam logic [7:0] CMD_INPUT  = 8'h00;
	localparam logic [7:0] CMD_OUTPUT = 8'h01;
	localparam logic [7:0] CMD_INVERT = 8'h02;
	localparam logic [7:0] CMD_DIR    = 8'h03;
	localparam logic [7:0] CMD_STATUS = 8'h04;
	localparam int ADDR_W = 5;
	// ==========================================================
	// reset values
	localparam logic [7:0] RST_OUTPUT = 8'hff;
	localparam logic [7:0] RST_INVERT = 8'h00;
	localparam logic [7:0] RST_DIR    = 8'hff;
	localparam logic [7:0] RST_INPUT  = 8'hff;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	// ==========================================================
	// power-on hold
	localparam int POR_NS = 400;
	localparam int CLK_NS = 40;
	localparam int POR_CYCLES = (POR_NS + CLK_NS - 1) / CLK_NS;

	typedef struct packed {
		logic [7:0] drive;
		logic [7:0] oe_n;
	} ioxi_pins_type;
endpackage

// File: test/ioxi_pin_model.sv
module ioxi_pin_model (
	input  wire logic                   [7:0] ext_level,
	input  wire ioxi_pkg::ioxi_pins_type      pins,
	input  wire logic                         alert_out,
	input  wire logic                         alert_oe_n,
	output logic                        [7:0] pin_in,
	output logic                              alert_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// pins the block does not drive follow the outside level
	assign pin_in = (pins.oe_n & ext_level) | (~pins.oe_n & pins.drive);
	// pull-up on the open-drain alert line
	assign alert_n = alert_oe_n ? 1'b1 : alert_out;
endmodule

// File: test/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic                    sys_clk, rst, supply_ok, avs_read, avs_write;
	logic                    avs_waitrequest, alert_out, alert_oe_n, alert_n;
	logic              [4:0] avs_address;
	logic             [31:0] avs_writedata, avs_readdata;
	logic              [7:0] pin_in, ext, r;
	ioxi_pkg::ioxi_pins_type pin_out;
	logic             [31:0] exp_q[$];
	int                      fail_count, compares;

	ioxi_top dut (.sys_clk(sys_clk), .rst(rst), .supply_ok(supply_ok),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pin_in(pin_in), .pin_out(pin_out), .alert_out(alert_out),
		.alert_oe_n(alert_oe_n));
	ioxi_pin_model far (.ext_level(ext), .pins(pin_out),
		.alert_out(alert_out), .alert_oe_n(alert_oe_n), .pin_in(pin_in),
		.alert_n(alert_n));

	// ==========================================================
	// bus and checks
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] s);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic bus(input logic wr, input logic [2:0] idx,
		input logic [7:0] d);
		@(posedge sys_clk);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h00_0000, d};
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] idx, input logic [7:0] e);
		exp_q.push_back({24'h00_0000, e});
		bus(1'b0, idx, 8'h00);
	endtask
	// alert path is two sync stages plus one register
	task automatic al(input logic e);
		repeat (6) @(posedge sys_clk);
		chk("alert_n", {31'h0, e}, {31'h0, alert_n});
	endtask
	task automatic defaults();
		rd(3'd1, 8'hff);
		rd(3'd2, 8'h00);
		rd(3'd3, 8'hff);
		rd(3'd0, ext);
		al(1'b1);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
			chk("readdata", exp_q.pop_front(), avs_readdata);
	end

	// ==========================================================
	// stimulus
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		fail_count++;
		tally_and_finish();
	end
	initial begin
		rst = 1'b1;
		supply_ok = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0000_0000;
		ext = 8'hff;
		fail_count = 0;
		compares = 0;
		void'($urandom(32'h176e_17f0));
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		defaults();
		r = 8'($urandom());
		bus(1'b1, 3'd3, 8'hf0);
		bus(1'b1, 3'd1, r);
		rd(3'd1, r);
		rd(3'd0, {4'hf, r[3:0]});
		bus(1'b1, 3'd1, ~r);
		al(1'b1);
		ext[5] <= 1'b0;
		al(1'b0);
		ext[5] <= 1'b1;
		al(1'b1);
		ext[6] <= 1'b0;
		al(1'b0);
		rd(3'd0, {4'hb, ~r[3:0]});
		al(1'b1);
		bus(1'b1, 3'd2, 8'haa);
		rd(3'd0, {4'hb, ~r[3:0]} ^ 8'haa);
		bus(1'b1, 3'd0, 8'h00);
		rd(3'd0, {4'hb, ~r[3:0]} ^ 8'haa);
		rd(3'd5, 8'h00);
		bus(1'b1, 3'd1, 8'h00);
		al(1'b1);
		rd(3'd0, 8'hb0 ^ 8'haa);
		// low pins turned to inputs now read high against the old reference
		bus(1'b1, 3'd3, 8'hff);
		al(1'b0);
		rd(3'd0, 8'hbf ^ 8'haa);
		al(1'b1);
		// pins back to idle so the re-powered block reads all ones
		ext[6] <= 1'b1;
		supply_ok <= 1'b0;
		repeat (5) @(posedge sys_clk);
		supply_ok <= 1'b1;
		defaults();
		tally_and_finish();
	end
endmodule
